// [srpm_top.sv]
// receive byte monitors, snapshot update and x.86 header checks behind apb
`timescale 1ns/1ps
`include "srpm_map.svh"

// How it works
// - count bytes of received packets without abort in a 32-bit counter
// - count bytes of aborted received packets in a separate 32-bit counter
// - bytes later dropped for fcs, loopback, reset or overflow may be counted
// - aborted count read as four bytes, least significant byte at lowest address
// - strobe 0 to 1 copies counters to readable registers, then resets counters
// - done bit sets when update finishes, clears when strobe written to zero
// - flag bit 3 when received high sapi differs from its reference
// - flag bit 2 when received low sapi differs from its reference
// - flag bit 1 when received control field differs from its reference
// - flag bit 0 when received address field differs from its reference
// - mismatch flags stay set until the mismatch register is read
// - each mismatch flag interrupts while its enable bit is one; any new mismatch also interrupts via status bit 1 when mask bit 1 is set
module srpm_top
    import srpm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive path events
    input wire srpm_pkt_type rx_pkt,
    input wire srpm_hdr_type rx_hdr,
    // interrupt
    output logic irq
);

    function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [1:0] sel);
        byte_of = word[8 * sel +: 8];
    endfunction : byte_of

    function automatic logic [31:0] bump(input logic [31:0] count, input logic hit,
                                         input logic [15:0] len);
        bump = hit ? count + {16'h0000, len} : count;
    endfunction : bump

    logic [31:0] good_byte_count;
    logic [31:0] aborted_byte_count;
    logic [31:0] good_snapshot;
    logic [31:0] aborted_snapshot;
    logic monitor_update_strobe;
    logic strobe_seen;
    logic monitor_update_done;
    srpm_upd_state_type upd_state;
    logic [3:0] x86_mismatch;
    logic [3:0] x86_mismatch_irq_enable;
    srpm_ref_type refs;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic [9:0] idx;
    logic [9:0] acc_idx;
    logic update_rise;
    logic [3:0] next_mismatch_set;
    logic [3:0] mismatch_clr;
    logic [31:0] next_prdata;
    logic next_pslverr;

    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;
    assign idx = paddr[11:2];
    assign acc_idx = paddr[11:2];
    assign update_rise = monitor_update_strobe & ~strobe_seen;

    // register read mux and decode, evaluated in the setup cycle
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        unique case (idx)
            `SRPM_IDX_GOOD_B0: next_prdata[7:0] = byte_of(good_snapshot, 2'd0);
            `SRPM_IDX_GOOD_B1: next_prdata[7:0] = byte_of(good_snapshot, 2'd1);
            `SRPM_IDX_GOOD_B2: next_prdata[7:0] = byte_of(good_snapshot, 2'd2);
            `SRPM_IDX_GOOD_B3: next_prdata[7:0] = byte_of(good_snapshot, 2'd3);
            `SRPM_IDX_ABORT_B0: next_prdata[7:0] = byte_of(aborted_snapshot, 2'd0);
            `SRPM_IDX_ABORT_B1: next_prdata[7:0] = byte_of(aborted_snapshot, 2'd1);
            `SRPM_IDX_ABORT_B2: next_prdata[7:0] = byte_of(aborted_snapshot, 2'd2);
            `SRPM_IDX_ABORT_B3: next_prdata[7:0] = byte_of(aborted_snapshot, 2'd3);
            `SRPM_IDX_UPD_STROBE: next_prdata[0] = monitor_update_strobe;
            `SRPM_IDX_UPD_DONE: next_prdata[0] = monitor_update_done;
            `SRPM_IDX_X86_MISMATCH: next_prdata[3:0] = x86_mismatch;
            `SRPM_IDX_X86_IRQ_EN: next_prdata[3:0] = x86_mismatch_irq_enable;
            `SRPM_IDX_ADDR_REF: next_prdata[7:0] = refs.address;
            `SRPM_IDX_CTRL_REF: next_prdata[7:0] = refs.control;
            `SRPM_IDX_SAPIL_REF: next_prdata[7:0] = refs.sapi_low;
            `SRPM_IDX_SAPIH_REF: next_prdata[7:0] = refs.sapi_high;
            `SRPM_IDX_IRQ_STATUS: next_prdata[1:0] = irq_status;
            `SRPM_IDX_IRQ_MASK: next_prdata[1:0] = irq_mask;
            default: next_pslverr = 1'b1;
        endcase
        if (paddr[1:0] != 2'b00) begin
            next_prdata = 32'h0000_0000;
            next_pslverr = 1'b1;
        end
    end

    // zero wait state: answer is prepared in setup and ready in the first access cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= next_prdata;
                pslverr <= next_pslverr;
            end
        end
    end

    // configuration registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            monitor_update_strobe <= 1'b0;
            x86_mismatch_irq_enable <= 4'h0;
            refs <= '0;
            irq_mask <= 2'b00;
        end else if (wr && !pslverr) begin
            unique case (acc_idx)
                `SRPM_IDX_UPD_STROBE: monitor_update_strobe <= pwdata[0];
                `SRPM_IDX_X86_IRQ_EN: x86_mismatch_irq_enable <= pwdata[3:0];
                `SRPM_IDX_ADDR_REF: refs.address <= pwdata[7:0];
                `SRPM_IDX_CTRL_REF: refs.control <= pwdata[7:0];
                `SRPM_IDX_SAPIL_REF: refs.sapi_low <= pwdata[7:0];
                `SRPM_IDX_SAPIH_REF: refs.sapi_high <= pwdata[7:0];
                `SRPM_IDX_IRQ_MASK: irq_mask <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // running counters; a packet ending in the update cycle lands in the fresh count
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            good_byte_count <= `SRPM_RST_COUNT;
            aborted_byte_count <= `SRPM_RST_COUNT;
        end else begin
            // lengths arrive as reported; dropped bytes are not subtracted
            good_byte_count <= bump(update_rise ? `SRPM_RST_COUNT : good_byte_count,
                                    rx_pkt.done & ~rx_pkt.aborted, rx_pkt.len);
            aborted_byte_count <= bump(update_rise ? `SRPM_RST_COUNT : aborted_byte_count,
                                       rx_pkt.done & rx_pkt.aborted, rx_pkt.len);
        end
    end

    // snapshot only on the strobe edge so multi-byte reads stay coherent
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_seen <= 1'b0;
            good_snapshot <= `SRPM_RST_COUNT;
            aborted_snapshot <= `SRPM_RST_COUNT;
        end else begin
            strobe_seen <= monitor_update_strobe;
            if (update_rise) begin
                good_snapshot <= good_byte_count;
                aborted_snapshot <= aborted_byte_count;
            end
        end
    end

    // completion tracking
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            upd_state <= SRPM_IDLE;
            monitor_update_done <= 1'b0;
        end else begin
            unique case (upd_state)
                SRPM_IDLE: begin
                    if (update_rise) begin
                        upd_state <= SRPM_DONE;
                        monitor_update_done <= 1'b1;
                    end
                end
                SRPM_DONE: begin
                    if (!monitor_update_strobe) begin
                        upd_state <= SRPM_IDLE;
                        monitor_update_done <= 1'b0;
                    end
                end
                default: begin
                    upd_state <= SRPM_IDLE;
                    monitor_update_done <= 1'b0;
                end
            endcase
        end
    end

    // header comparison against references
    always_comb begin
        next_mismatch_set = 4'h0;
        if (rx_hdr.valid) begin
            next_mismatch_set[`SRPM_BIT_SAPIH] = rx_hdr.sapi_high != refs.sapi_high;
            next_mismatch_set[`SRPM_BIT_SAPIL] = rx_hdr.sapi_low != refs.sapi_low;
            next_mismatch_set[`SRPM_BIT_CTRL] = rx_hdr.control != refs.control;
            next_mismatch_set[`SRPM_BIT_ADDR] = rx_hdr.address != refs.address;
        end
    end

    // only the bits actually returned to software are cleared by the read
    assign mismatch_clr = (rd && !pslverr && acc_idx == `SRPM_IDX_X86_MISMATCH) ?
                          prdata[3:0] : 4'h0;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            x86_mismatch <= 4'h0;
        end else begin
            x86_mismatch <= (x86_mismatch & ~mismatch_clr) | next_mismatch_set;
        end
    end

    // sticky event status, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= 2'b00;
        end else begin
            irq_status <= (irq_status &
                           ~((wr && !pslverr && acc_idx == `SRPM_IDX_IRQ_STATUS) ?
                             pwdata[1:0] : 2'b00))
                          | {|next_mismatch_set, update_rise};
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (|(x86_mismatch & x86_mismatch_irq_enable)) | (|(irq_status & irq_mask));
        end
    end

endmodule : srpm_top

// [srpm_map.svh]
// register offsets, field positions, reset values for the receive monitor block
`ifndef SRPM_MAP_SVH
`define SRPM_MAP_SVH
`define SRPM_IDX_GOOD_B0 10'h118
`define SRPM_IDX_GOOD_B1 10'h119
`define SRPM_IDX_GOOD_B2 10'h11a
`define SRPM_IDX_GOOD_B3 10'h11b
`define SRPM_IDX_ABORT_B0 10'h11c
`define SRPM_IDX_ABORT_B1 10'h11d
`define SRPM_IDX_ABORT_B2 10'h11e
`define SRPM_IDX_ABORT_B3 10'h11f
`define SRPM_IDX_UPD_STROBE 10'h120
`define SRPM_IDX_UPD_DONE 10'h121
`define SRPM_IDX_X86_MISMATCH 10'h122
`define SRPM_IDX_X86_IRQ_EN 10'h123
`define SRPM_IDX_ADDR_REF 10'h128
`define SRPM_IDX_CTRL_REF 10'h129
`define SRPM_IDX_SAPIL_REF 10'h12a
`define SRPM_IDX_SAPIH_REF 10'h12b
`define SRPM_IDX_IRQ_STATUS 10'h12c
`define SRPM_IDX_IRQ_MASK 10'h12d
`define SRPM_BIT_ADDR 0
`define SRPM_BIT_CTRL 1
`define SRPM_BIT_SAPIL 2
`define SRPM_BIT_SAPIH 3
`define SRPM_BIT_EV_DONE 0
`define SRPM_BIT_EV_X86 1
`define SRPM_RST_BYTE 8'h00
`define SRPM_RST_COUNT 32'h0000_0000
`endif

// [srpm_pkg.sv]
// types shared by the receive monitor block
package srpm_pkg;
    typedef struct packed {
        logic done;
        logic aborted;
        logic [15:0] len;
    } srpm_pkt_type;

    typedef struct packed {
        logic valid;
        logic [7:0] address;
        logic [7:0] control;
        logic [7:0] sapi_high;
        logic [7:0] sapi_low;
    } srpm_hdr_type;

    typedef struct packed {
        logic [7:0] address;
        logic [7:0] control;
        logic [7:0] sapi_low;
        logic [7:0] sapi_high;
    } srpm_ref_type;

    typedef enum logic [1:0] {
        SRPM_IDLE = 2'b01,
        SRPM_DONE = 2'b10
    } srpm_upd_state_type;
endpackage : srpm_pkg

// [srpm_top_sva.sv]
// port-level assertions for the receive monitor block
`timescale 1ns/1ps
`include "srpm_map.svh"
module srpm_top_chk
    import srpm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // receive path and interrupt
    input wire srpm_pkt_type rx_pkt,
    input wire srpm_hdr_type rx_hdr,
    input wire logic irq
);
    localparam logic [11:0] A_STB = {`SRPM_IDX_UPD_STROBE, 2'b00};
    localparam logic [11:0] A_DONE = {`SRPM_IDX_UPD_DONE, 2'b00};
    localparam logic [11:0] A_MIS = {`SRPM_IDX_X86_MISMATCH, 2'b00};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire logic setup = psel && !penable;
    wire logic xfer = psel && penable && pready;
    wire logic wr_stb = xfer && pwrite && paddr == A_STB;
    wire logic v = rx_hdr.valid;
    AST_READY_AFTER_SETUP:
        assert property (setup |=> pready) else $error("no pready after setup");
    AST_READY_CAUSE:
        assert property (pready |-> $past(setup)) else $error("pready without setup");
    AST_BAD_ADDR_ERR:
        assert property (setup && (paddr[1:0] != 2'h0 || paddr[11:2] == 10'h124)
            |=> pslverr && prdata == 32'h0) else $error("bad address not refused");
    AST_MAPPED_OK:
        assert property (setup && paddr[11:2] == `SRPM_IDX_ABORT_B3 && paddr[1:0] == 2'h0
            |=> !pslverr) else $error("mapped register refused");
    AST_HIGH_BITS_ZERO:
        assert property (pready |-> prdata[31:8] == 24'h0) else $error("high bits set");
    AST_DONE_SETS:
        assert property (wr_stb && pwdata[0] ##2 setup && !pwrite && paddr == A_DONE
            |=> prdata[0]) else $error("done not set after update");
    AST_DONE_CLEARS:
        assert property (wr_stb && !pwdata[0] ##2 setup && !pwrite && paddr == A_DONE
            |=> !prdata[0]) else $error("done not cleared");
    AST_READ_CLEARS:
        assert property (setup && !pwrite && paddr == A_MIS && !v ##1 xfer && !v
            ##1 !psel && !v ##1 setup && !pwrite && paddr == A_MIS |=> prdata[3:0] == 4'h0)
            else $error("mismatch flags survived read");
    AST_IRQ_FALL:
        assert property ($fell(irq) |-> $past(psel, 2)) else $error("irq fell unprompted");
    cover property (wr_stb && pwdata[0]);
    cover property ($rose(irq));
    cover property (pready && pslverr);
    cover property (rx_pkt.done && rx_pkt.aborted);
endmodule : srpm_top_chk

// [srpm_top_test.sv]
// self-checking bench for the receive monitor block
`timescale 1ns/1ps
`include "srpm_map.svh"
module srpm_top_test
    import srpm_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    srpm_pkt_type rx_pkt = '0;
    srpm_hdr_type rx_hdr = '0;
    logic irq;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] rdat;
    logic rerr;
    localparam logic [31:0] GOOD = 32'h0102_0101;
    localparam logic [31:0] ABRT = 32'h0001_01fe;
    always #50 ref_clk = ~ref_clk;
    srpm_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_pkt(rx_pkt), .rx_hdr(rx_hdr), .irq(irq));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input string what);
        apb(1'b0, {idx, 2'b00}, 32'h0);
        check(what, exp, rdat);
    endtask : rd
    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        apb(1'b1, {idx, 2'b00}, wd);
    endtask : wr
    // n packets back to back
    task automatic pkt(input logic ab, input logic [15:0] len, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            rx_pkt <= {1'b1, ab, len};
        end
        @(posedge ref_clk);
        rx_pkt <= '0;
    endtask : pkt
    task automatic t_reset();
        for (int i = 0; i < 11; i++) begin
            rd(`SRPM_IDX_GOOD_B0 + 10'(i), 32'h0, "reset value");
        end
        apb(1'b0, 12'h490, 32'h0);
        check("unmapped error", 32'h1, {31'h0, rerr});
        apb(1'b0, 12'h461, 32'h0);
        check("unaligned error", 32'h1, {31'h0, rerr});
    endtask : t_reset
    task automatic t_counts();
        pkt(1'b0, 16'hffff, 258);
        pkt(1'b1, 16'h80ff, 2);
        pkt(1'b0, 16'h0203, 1);
        rd(`SRPM_IDX_GOOD_B0, 32'h0, "snapshot before update");
        wr(`SRPM_IDX_GOOD_B0, 32'hff);
        wr(`SRPM_IDX_UPD_STROBE, 32'h1);
        rd(`SRPM_IDX_UPD_DONE, 32'h1, "update done");
        for (int i = 0; i < 4; i++) begin
            rd(`SRPM_IDX_GOOD_B0 + 10'(i), {24'h0, GOOD[8*i +: 8]}, "good byte");
            rd(`SRPM_IDX_ABORT_B0 + 10'(i), {24'h0, ABRT[8*i +: 8]}, "aborted byte");
        end
        pkt(1'b0, 16'h0005, 1);
        rd(`SRPM_IDX_GOOD_B0, 32'h01, "snapshot held");
        wr(`SRPM_IDX_UPD_STROBE, 32'h0);
        rd(`SRPM_IDX_UPD_DONE, 32'h0, "done cleared");
        wr(`SRPM_IDX_UPD_STROBE, 32'h1);
        rd(`SRPM_IDX_GOOD_B0, 32'h05, "count restarted");
        rd(`SRPM_IDX_ABORT_B1, 32'h00, "aborted restarted");
    endtask : t_counts
    task automatic t_irq();
        rd(`SRPM_IDX_IRQ_STATUS, 32'h1, "done event");
        check("irq masked", 32'h0, {31'h0, irq});
        wr(`SRPM_IDX_IRQ_MASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        check("irq unmasked", 32'h1, {31'h0, irq});
        wr(`SRPM_IDX_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge ref_clk);
        check("irq after clear", 32'h0, {31'h0, irq});
        rd(`SRPM_IDX_IRQ_STATUS, 32'h0, "status cleared");
    endtask : t_irq
    task automatic t_x86();
        logic [31:0] f;
        for (int i = 0; i < 4; i++) begin
            wr(`SRPM_IDX_ADDR_REF + 10'(i), 32'h11 * (i + 1));
        end
        // one field wrong at a time; refs sit in flag bit order
        for (int i = 0; i < 4; i++) begin
            f = 32'h4433_2211 ^ (32'hff << (8 * i));
            wr(`SRPM_IDX_X86_IRQ_EN, 32'h0);
            @(posedge ref_clk);
            rx_hdr <= {1'b1, f[7:0], f[15:8], f[31:24], f[23:16]};
            @(posedge ref_clk);
            rx_hdr <= '0;
            repeat (2) @(posedge ref_clk);
            check("irq disabled", 32'h0, {31'h0, irq});
            wr(`SRPM_IDX_X86_IRQ_EN, 32'h1 << i);
            repeat (2) @(posedge ref_clk);
            check("irq enabled", 32'h1, {31'h0, irq});
            rd(`SRPM_IDX_X86_MISMATCH, 32'h1 << i, "mismatch flag");
            rd(`SRPM_IDX_X86_MISMATCH, 32'h0, "flag after read");
        end
    endtask : t_x86
    task automatic stop_test();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_counts();
        t_irq();
        t_x86();
        stop_test();
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        stop_test();
    end
endmodule : srpm_top_test
bind srpm_top srpm_top_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pkt(rx_pkt), .rx_hdr(rx_hdr), .irq(irq));
